// >>> rtl/supply_state_pkg.sv
// package: offsets, fields, reset values and bus carriers of the supply state block
`default_nettype none
package supply_state_pkg;

    // sfr space offsets
    localparam logic [7:0]  SYSTEM_STATE_ADDR     = 8'hA1;
    localparam logic [7:0]  WAKE_SOURCE_ADDR      = 8'hAF;
    // external data space offset
    localparam logic [15:0] REGULATOR_CTRL_ADDR   = 16'h2866;

    // system_state field positions
    localparam int unsigned LINE_SUPPLY_BIT       = 0;
    localparam int unsigned SUPPLY_LOW_BIT        = 1;
    localparam int unsigned TIMER_PULSE_WAKE_BIT  = 2;
    localparam int unsigned PIN_WAKE_BIT          = 3;
    localparam int unsigned LEVEL1_RESET_BIT      = 5;

    // wake_source_reg field position
    localparam int unsigned PULSE_QUALIFIER_BIT   = 3;

    // regulator_control_reg field positions
    localparam int unsigned DETECT_DISABLE_BIT    = 7;
    localparam int unsigned ANALOG_LEVEL_LSB      = 3;
    localparam int unsigned CORE_LEVEL_LSB        = 0;
    localparam int unsigned LEVEL_WIDTH           = 3;

    // values after reset and of unmapped reads
    localparam logic        STATUS_RESET          = 1'b0;
    localparam logic        DETECT_DISABLE_RESET  = 1'b0;
    localparam logic [2:0]  ANALOG_LEVEL_RESET    = 3'h0;
    localparam logic [2:0]  CORE_LEVEL_RESET      = 3'h0;
    localparam logic [7:0]  READ_DATA_RESET       = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ_VALUE   = 8'h00;

    // synchroniser depth and number of asynchronous inputs
    localparam int unsigned SYNC_STAGES           = 2;
    localparam int unsigned ASYNC_INPUTS          = 5;

    // index of each asynchronous input in the synchroniser bank
    localparam int unsigned IDX_BELOW_LOW         = 0;
    localparam int unsigned IDX_ABOVE_HIGH        = 1;
    localparam int unsigned IDX_WAKE_PIN          = 2;
    localparam int unsigned IDX_WAKE_TIMER        = 3;
    localparam int unsigned IDX_WAKE_PULSE        = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } xdata_req_t;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [7:0] data;
    } read_rsp_t;

    typedef struct packed {
        logic       detect_disable;
        logic [2:0] analog_level;
        logic [2:0] core_level;
    } regulator_ctrl_t;

endpackage : supply_state_pkg
`default_nettype wire

// >>> rtl/level_sync.sv
// two flip-flop level synchroniser for one asynchronous input
`default_nettype none
module level_sync (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output var  logic o_sync
);
    import supply_state_pkg::*;

    logic meta;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule : level_sync
`default_nettype wire

// >>> rtl/supply_supervisor_state_flags.sv
// supply supervisor: reset cause, wakeup source, supply state and regulator control
//
// Contract
// [R1] Set the level-1 reset flag after a level-1 reset and clear it on any reset of another level.
// [R2] Set the pin wake flag when a pin wakeup event takes the system out of Sleep or Deep Sleep.
// [R3] On a timer wakeup from Sleep read the timer/pulse wake flag as 1 and the pulse qualifier as 0.
// [R4] On an energy-pulse wakeup from Sleep read both the timer/pulse wake flag and the qualifier as 1.
// [R5] Read the supply low flag as 1 whenever the mains sense voltage is below the low threshold; the code holds the flag while detect disable is 1.
// [R6] On a power-down event set the supply low flag and raise an interrupt request when it is enabled.
// [R7] Hold the supply low flag at 0 while the mains sense voltage is above the high threshold.
// [R8] Read the line supply flag as 1 while the mains sense voltage is above the high threshold.
// [R9] Keep the line supply flag at 0 while the mains sense voltage is below the low threshold.
// [R10] Supply detection is on by default and turned off by writing 1 to the detect disable bit.
// [R11] Provide a three-bit analog and pin regulator level field in the regulator control register.
// [R12] Provide a three-bit core regulator level field in the regulator control register.
// [R13] The system state register is read-only, its bits 7, 6 and 4 are reserved and its status resets to 0.
// [R14] Synchronise comparator outputs and wakeup indications to the clock before they touch any flag.
`default_nettype none
module supply_supervisor_state_flags (
    input  wire logic                         i_mclk,
    input  wire logic                         i_rst_n,
    // special-function register bus
    input  wire supply_state_pkg::sfr_req_t   i_sfr_req,
    output var  supply_state_pkg::read_rsp_t  o_sfr_rsp,
    // external data bus
    input  wire supply_state_pkg::xdata_req_t i_xdata_req,
    output var  supply_state_pkg::read_rsp_t  o_xdata_rsp,
    // reset and sleep controller, same clock
    input  wire logic                         i_other_reset,
    input  wire logic                         i_sleep,
    input  wire logic                         i_deep_sleep,
    input  wire logic                         i_supply_low_flag_irq_enable,
    // asynchronous comparator outputs and wakeup indications
    input  wire logic                         i_mains_below_low,
    input  wire logic                         i_mains_above_high,
    input  wire logic                         i_wake_pin,
    input  wire logic                         i_wake_timer,
    input  wire logic                         i_wake_pulse,
    // outputs
    output var  logic                         o_supply_low_flag_irq,
    output var  logic                         o_supply_detect_enable,
    output var  supply_state_pkg::regulator_ctrl_t o_regulator
);
    import supply_state_pkg::*;

    // address match; xdata_match is used by read and write decode, sfr_match by read decode only
    function automatic logic sfr_match(input logic [7:0] addr, input logic [7:0] target);
        sfr_match = (addr == target);
    endfunction : sfr_match

    function automatic logic xdata_match(input logic [15:0] addr, input logic [15:0] target);
        xdata_match = (addr == target);
    endfunction : xdata_match

    // synchronised asynchronous inputs
    logic [ASYNC_INPUTS-1:0] async_in;
    logic [ASYNC_INPUTS-1:0] sync_in;
    logic [ASYNC_INPUTS-1:0] sync_prev;
    logic [ASYNC_INPUTS-1:0] sync_rise;

    assign async_in[IDX_BELOW_LOW]  = i_mains_below_low;
    assign async_in[IDX_ABOVE_HIGH] = i_mains_above_high;
    assign async_in[IDX_WAKE_PIN]   = i_wake_pin;
    assign async_in[IDX_WAKE_TIMER] = i_wake_timer;
    assign async_in[IDX_WAKE_PULSE] = i_wake_pulse;

    genvar gi;
    generate
        for (gi = 0; gi < ASYNC_INPUTS; gi++) begin : g_sync
            level_sync u_sync (
                .i_mclk  (i_mclk),
                .i_rst_n (i_rst_n),
                .i_async (async_in[gi]),
                .o_sync  (sync_in[gi])
            ); // [R14]
        end
    endgenerate

    // edge detection works on synchronised levels only
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_prev <= '0;
        end else begin
            sync_prev <= sync_in;
        end
    end

    assign sync_rise = sync_in & ~sync_prev; // [R14]

    // status and control state
    logic            level1_reset_flag;
    logic            level1_pending;
    logic            pin_wake_flag;
    logic            timer_or_pulse_wake_flag;
    logic            pulse_wake_qualifier;
    logic            supply_low_flag;
    logic            line_supply_flag;
    logic            sleeping;
    logic            sleeping_prev;
    logic            sleep_entry;
    logic            light_sleep;
    regulator_ctrl_t regulator;
    logic [7:0]      system_state;
    logic [7:0]      wake_source;
    logic [7:0]      regulator_byte;
    logic            sfr_state_hit;
    logic            sfr_wake_hit;
    logic            xdata_reg_hit;

    assign sleeping    = i_sleep | i_deep_sleep;
    assign light_sleep = i_sleep & ~i_deep_sleep;
    assign sleep_entry = sleeping & ~sleeping_prev;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleeping_prev <= 1'b0;
        end else begin
            sleeping_prev <= sleeping;
        end
    end

    // reset cause: the block itself is reset only by a level-1 reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level1_pending <= 1'b1;
        end else begin
            level1_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level1_reset_flag <= STATUS_RESET; // [R13]
        end else if (level1_pending) begin
            level1_reset_flag <= 1'b1; // [R1]
        end else if (i_other_reset) begin
            level1_reset_flag <= 1'b0; // [R1]
        end
    end

    // pin wakeup from either sleep state, set wins over clear on sleep entry
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_wake_flag <= STATUS_RESET; // [R13]
        end else if (sleeping && sync_rise[IDX_WAKE_PIN]) begin
            pin_wake_flag <= 1'b1; // [R2]
        end else if (sleep_entry) begin
            pin_wake_flag <= 1'b0;
        end
    end

    // timer and pulse wakeups leave light sleep only
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_or_pulse_wake_flag <= STATUS_RESET; // [R13]
        end else if (light_sleep && (sync_rise[IDX_WAKE_TIMER] || sync_rise[IDX_WAKE_PULSE])) begin
            timer_or_pulse_wake_flag <= 1'b1; // [R3] [R4]
        end else if (sleep_entry) begin
            timer_or_pulse_wake_flag <= 1'b0;
        end
    end

    // qualifier tells a pulse wakeup from a timer wakeup; pulse wins if both arrive
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse_wake_qualifier <= STATUS_RESET;
        end else if (light_sleep && sync_rise[IDX_WAKE_PULSE]) begin
            pulse_wake_qualifier <= 1'b1; // [R4]
        end else if (light_sleep && sync_rise[IDX_WAKE_TIMER]) begin
            pulse_wake_qualifier <= 1'b0; // [R3]
        end else if (sleep_entry) begin
            pulse_wake_qualifier <= 1'b0;
        end
    end

    // supply state with hysteresis between the two comparators; frozen while detection is off
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            supply_low_flag <= STATUS_RESET; // [R13]
        end else if (!regulator.detect_disable) begin
            if (sync_in[IDX_BELOW_LOW]) begin
                supply_low_flag <= 1'b1; // [R5] [R6]
            end else if (sync_in[IDX_ABOVE_HIGH]) begin
                supply_low_flag <= 1'b0; // [R7]
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_supply_flag <= STATUS_RESET; // [R13]
        end else if (!regulator.detect_disable) begin
            if (sync_in[IDX_BELOW_LOW]) begin
                line_supply_flag <= 1'b0; // [R9]
            end else if (sync_in[IDX_ABOVE_HIGH]) begin
                line_supply_flag <= 1'b1; // [R8]
            end
        end
    end

    // power-down interrupt request, level while flag and enable are both high
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_supply_low_flag_irq <= 1'b0;
        end else begin
            o_supply_low_flag_irq <= supply_low_flag & i_supply_low_flag_irq_enable; // [R6]
        end
    end

    // register images; reserved bits read as zero
    always_comb begin
        system_state                       = 8'h00; // [R13]
        system_state[LEVEL1_RESET_BIT]     = level1_reset_flag;
        system_state[PIN_WAKE_BIT]         = pin_wake_flag;
        system_state[TIMER_PULSE_WAKE_BIT] = timer_or_pulse_wake_flag;
        system_state[SUPPLY_LOW_BIT]       = supply_low_flag;
        system_state[LINE_SUPPLY_BIT]      = line_supply_flag;
    end

    always_comb begin
        wake_source                      = 8'h00;
        wake_source[PULSE_QUALIFIER_BIT] = pulse_wake_qualifier;
    end

    always_comb begin
        regulator_byte                                            = 8'h00;
        regulator_byte[DETECT_DISABLE_BIT]                        = regulator.detect_disable;
        regulator_byte[ANALOG_LEVEL_LSB +: LEVEL_WIDTH]           = regulator.analog_level;
        regulator_byte[CORE_LEVEL_LSB +: LEVEL_WIDTH]             = regulator.core_level;
    end

    // address decode
    assign sfr_state_hit = sfr_match(i_sfr_req.addr, SYSTEM_STATE_ADDR);
    assign sfr_wake_hit  = sfr_match(i_sfr_req.addr, WAKE_SOURCE_ADDR);
    assign xdata_reg_hit = xdata_match(i_xdata_req.addr, REGULATOR_CTRL_ADDR);

    // regulator control register; sfr writes to the state register are ignored
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            regulator.detect_disable <= DETECT_DISABLE_RESET; // [R10]
            regulator.analog_level   <= ANALOG_LEVEL_RESET;
            regulator.core_level     <= CORE_LEVEL_RESET;
        end else if (i_xdata_req.wr && xdata_reg_hit) begin
            regulator.detect_disable <= i_xdata_req.wdata[DETECT_DISABLE_BIT]; // [R10]
            regulator.analog_level   <= i_xdata_req.wdata[ANALOG_LEVEL_LSB +: LEVEL_WIDTH]; // [R11]
            regulator.core_level     <= i_xdata_req.wdata[CORE_LEVEL_LSB +: LEVEL_WIDTH]; // [R12]
        end
    end

    assign o_regulator            = regulator; // [R11] [R12]
    assign o_supply_detect_enable = ~regulator.detect_disable; // [R10]

    // sfr read port, answer one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sfr_rsp.valid <= 1'b0;
            o_sfr_rsp.hit   <= 1'b0;
            o_sfr_rsp.data  <= READ_DATA_RESET;
        end else begin
            o_sfr_rsp.valid <= i_sfr_req.rd;
            if (i_sfr_req.rd) begin
                if (sfr_state_hit) begin
                    o_sfr_rsp.hit  <= 1'b1;
                    o_sfr_rsp.data <= system_state; // [R13]
                end else if (sfr_wake_hit) begin
                    o_sfr_rsp.hit  <= 1'b1;
                    o_sfr_rsp.data <= wake_source; // [R3] [R4]
                end else begin
                    o_sfr_rsp.hit  <= 1'b0;
                    o_sfr_rsp.data <= UNMAPPED_READ_VALUE;
                end
            end
        end
    end

    // external data read port, answer one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_xdata_rsp.valid <= 1'b0;
            o_xdata_rsp.hit   <= 1'b0;
            o_xdata_rsp.data  <= READ_DATA_RESET;
        end else begin
            o_xdata_rsp.valid <= i_xdata_req.rd;
            if (i_xdata_req.rd) begin
                if (xdata_reg_hit) begin
                    o_xdata_rsp.hit  <= 1'b1;
                    o_xdata_rsp.data <= regulator_byte;
                end else begin
                    o_xdata_rsp.hit  <= 1'b0;
                    o_xdata_rsp.data <= UNMAPPED_READ_VALUE;
                end
            end
        end
    end

endmodule : supply_supervisor_state_flags
`default_nettype wire

// >>> verif/supply_supervisor_monitor.sv
// port checker of the supply supervisor
`default_nettype none
module supply_supervisor_monitor (
    input wire logic                              i_mclk,
    input wire logic                              i_rst_n,
    input wire supply_state_pkg::sfr_req_t        i_sfr_req,
    input wire supply_state_pkg::read_rsp_t       o_sfr_rsp,
    input wire supply_state_pkg::xdata_req_t      i_xdata_req,
    input wire supply_state_pkg::read_rsp_t       o_xdata_rsp,
    input wire logic                              i_other_reset,
    input wire logic                              i_sleep,
    input wire logic                              i_deep_sleep,
    input wire logic                              i_supply_low_flag_irq_enable,
    input wire logic                              i_mains_below_low,
    input wire logic                              i_mains_above_high,
    input wire logic                              i_wake_pin,
    input wire logic                              i_wake_timer,
    input wire logic                              i_wake_pulse,
    input wire logic                              o_supply_low_flag_irq,
    input wire logic                              o_supply_detect_enable,
    input wire supply_state_pkg::regulator_ctrl_t o_regulator
);
    timeunit 1ns;
    timeprecision 100ps;
    import supply_state_pkg::*;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic       reg_wr;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // last sfr address and xdata write data
    always_ff @(posedge i_mclk) begin
        addr_q  <= i_sfr_req.addr;
        wdata_q <= i_xdata_req.wdata;
    end
    assign reg_wr = i_xdata_req.wr && (i_xdata_req.addr == REGULATOR_CTRL_ADDR);

    a_read_answer: assert property (i_sfr_req.rd |=> o_sfr_rsp.valid)
        else $error("read without answer");
    a_no_stray: assert property (!i_sfr_req.rd |=> !o_sfr_rsp.valid)
        else $error("answer without read");
    a_reserved_zero: assert property (o_sfr_rsp.valid && addr_q == SYSTEM_STATE_ADDR |->
        o_sfr_rsp.hit && o_sfr_rsp.data[7:6] == 2'b00 && !o_sfr_rsp.data[4])
        else $error("state read shows reserved bits");
    a_unmapped_zero: assert property (o_sfr_rsp.valid && addr_q != SYSTEM_STATE_ADDR &&
        addr_q != WAKE_SOURCE_ADDR |-> !o_sfr_rsp.hit && o_sfr_rsp.data == 8'h00)
        else $error("unmapped read not empty");
    a_detect_inverse: assert property (o_supply_detect_enable == !o_regulator.detect_disable)
        else $error("detect enable disagrees with register");
    a_reg_write: assert property (reg_wr |=> o_regulator == {wdata_q[7], wdata_q[5:0]})
        else $error("regulator write lost");
    a_reg_hold: assert property (!reg_wr |=> $stable(o_regulator))
        else $error("regulator changed without write");
    a_irq_off: assert property (!i_supply_low_flag_irq_enable |=> !o_supply_low_flag_irq)
        else $error("irq while disabled");
    a_low_irq: assert property ((i_mains_below_low && i_supply_low_flag_irq_enable &&
        !o_regulator.detect_disable) [*5] |-> o_supply_low_flag_irq)
        else $error("no irq on supply low");

    c_reg_write: cover property (reg_wr);
    c_irq_rise: cover property ($rose(o_supply_low_flag_irq));
    c_state_hit: cover property (o_sfr_rsp.valid && o_sfr_rsp.hit);
endmodule : supply_supervisor_monitor
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench of the supply supervisor
`default_nettype none
module tb_top import supply_state_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [6:0]  expect_reg;
    } reg_row_t;
    localparam reg_row_t ROWS [5] = '{'{16'h2866, 8'hAD, 7'h6D}, '{16'h2867, 8'h00, 7'h6D},
        '{16'h2866, 8'h52, 7'h12}, '{16'h2866, 8'hFF, 7'h7F}, '{16'h2866, 8'h40, 7'h00}};
    logic            i_mclk = 1'b0;
    logic            i_rst_n, i_other_reset, i_sleep, i_deep_sleep, i_supply_low_flag_irq_enable;
    logic            i_mains_below_low, i_mains_above_high, i_wake_pin, i_wake_timer, i_wake_pulse;
    logic            o_supply_low_flag_irq, o_supply_detect_enable;
    sfr_req_t        i_sfr_req;
    xdata_req_t      i_xdata_req;
    read_rsp_t       o_sfr_rsp, o_xdata_rsp, rsp;
    regulator_ctrl_t o_regulator;
    int              failures = 0;
    int              check_count = 0;

    always #5 i_mclk = ~i_mclk;

    supply_supervisor_state_flags supply_supervisor_state_flags_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_req(i_sfr_req), .o_sfr_rsp(o_sfr_rsp),
        .i_xdata_req(i_xdata_req), .o_xdata_rsp(o_xdata_rsp), .i_other_reset(i_other_reset),
        .i_sleep(i_sleep), .i_deep_sleep(i_deep_sleep), .i_supply_low_flag_irq_enable(i_supply_low_flag_irq_enable),
        .i_mains_below_low(i_mains_below_low), .i_mains_above_high(i_mains_above_high),
        .i_wake_pin(i_wake_pin), .i_wake_timer(i_wake_timer), .i_wake_pulse(i_wake_pulse),
        .o_supply_low_flag_irq(o_supply_low_flag_irq), .o_supply_detect_enable(o_supply_detect_enable),
        .o_regulator(o_regulator));

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic rd(input logic x, input logic [15:0] a);
        @(negedge i_mclk);
        if (x) i_xdata_req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        else i_sfr_req = '{addr: a[7:0], rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(posedge i_mclk);
        #1;
        rsp = x ? o_xdata_rsp : o_sfr_rsp;
        chk("valid", {7'h00, rsp.valid}, 8'h01);
        @(negedge i_mclk);
        i_xdata_req.rd = 1'b0;
        i_sfr_req.rd = 1'b0;
    endtask : rd

    task automatic wr(input logic x, input logic [15:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        if (x) i_xdata_req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        else i_sfr_req = '{addr: a[7:0], rd: 1'b0, wr: 1'b1, wdata: d};
        @(negedge i_mclk);
        i_xdata_req.wr = 1'b0;
        i_sfr_req.wr = 1'b0;
    endtask : wr

    task automatic state(input logic [7:0] a, input logic [7:0] e);
        rd(1'b0, {8'h00, a});
        chk("state_read", rsp.data, e);
    endtask : state

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        {i_other_reset, i_sleep, i_deep_sleep, i_supply_low_flag_irq_enable} = 4'h0;
        {i_mains_below_low, i_mains_above_high, i_wake_pin, i_wake_timer, i_wake_pulse} = 5'h00;
        i_sfr_req = '0;
        i_xdata_req = '0;
        i_rst_n = 1'b0;
        repeat (6) @(negedge i_mclk);
        i_rst_n = 1'b1;
        foreach (ROWS[k]) begin
            wr(1'b1, ROWS[k].addr, ROWS[k].wdata);
            chk("regulator", {1'b0, o_regulator}, {1'b0, ROWS[k].expect_reg});
            chk("detect_en", {7'h00, o_supply_detect_enable}, {7'h00, ~ROWS[k].expect_reg[6]});
        end
        state(SYSTEM_STATE_ADDR, 8'h20);
        state(WAKE_SOURCE_ADDR, 8'h00);
        rd(1'b1, REGULATOR_CTRL_ADDR);
        chk("xdata_hit", {7'h00, rsp.hit}, 8'h01);
        chk("xdata_data", rsp.data, 8'h00);
        rd(1'b1, 16'h2867);
        chk("xdata_miss", {rsp.hit, rsp.data[6:0]}, 8'h00);
        i_supply_low_flag_irq_enable = 1'b1;
        i_mains_above_high = 1'b1;
        repeat (5) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h21);
        chk("irq", {7'h00, o_supply_low_flag_irq}, 8'h00);
        i_mains_above_high = 1'b0;
        i_mains_below_low = 1'b1;
        state(SYSTEM_STATE_ADDR, 8'h21);
        repeat (4) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h22);
        chk("irq", {7'h00, o_supply_low_flag_irq}, 8'h01);
        i_supply_low_flag_irq_enable = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk("irq", {7'h00, o_supply_low_flag_irq}, 8'h00);
        wr(1'b0, {8'h00, SYSTEM_STATE_ADDR}, 8'hFF);
        state(SYSTEM_STATE_ADDR, 8'h22);
        rd(1'b0, 16'h00A2);
        chk("sfr_miss", {rsp.hit, rsp.data[6:0]}, 8'h00);
        i_deep_sleep = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_wake_pin = 1'b1;
        repeat (5) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h2A);
        i_deep_sleep = 1'b0;
        i_sleep = 1'b1;
        i_wake_timer = 1'b1;
        repeat (5) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h2E);
        state(WAKE_SOURCE_ADDR, 8'h00);
        i_wake_pulse = 1'b1;
        repeat (5) @(negedge i_mclk);
        state(WAKE_SOURCE_ADDR, 8'h08);
        state(SYSTEM_STATE_ADDR, 8'h2E);
        {i_sleep, i_wake_pin, i_wake_timer, i_wake_pulse} = 4'h0;
        i_other_reset = 1'b1;
        @(negedge i_mclk);
        i_other_reset = 1'b0;
        state(SYSTEM_STATE_ADDR, 8'h0E);
        wr(1'b1, REGULATOR_CTRL_ADDR, 8'hAD);
        rd(1'b1, REGULATOR_CTRL_ADDR);
        chk("xdata_data", rsp.data, 8'hAD);
        i_rst_n = 1'b0;
        #1;
        chk("regulator", {1'b0, o_regulator}, 8'h00);
        chk("detect_en", {7'h00, o_supply_detect_enable}, 8'h01);
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (5) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h22);
        wr(1'b1, REGULATOR_CTRL_ADDR, 8'h80);
        {i_mains_below_low, i_mains_above_high} = 2'b01;
        repeat (5) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h22);
        wr(1'b1, REGULATOR_CTRL_ADDR, 8'h00);
        repeat (5) @(negedge i_mclk);
        state(SYSTEM_STATE_ADDR, 8'h21);
        conclude();
    end

    initial begin
        repeat (3000) @(posedge i_mclk);
        failures++;
        conclude();
    end
endmodule : tb_top

bind supply_supervisor_state_flags supply_supervisor_monitor supply_supervisor_monitor_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_req(i_sfr_req), .o_sfr_rsp(o_sfr_rsp),
    .i_xdata_req(i_xdata_req), .o_xdata_rsp(o_xdata_rsp), .i_other_reset(i_other_reset),
    .i_sleep(i_sleep), .i_deep_sleep(i_deep_sleep), .i_supply_low_flag_irq_enable(i_supply_low_flag_irq_enable),
    .i_mains_below_low(i_mains_below_low), .i_mains_above_high(i_mains_above_high),
    .i_wake_pin(i_wake_pin), .i_wake_timer(i_wake_timer), .i_wake_pulse(i_wake_pulse),
    .o_supply_low_flag_irq(o_supply_low_flag_irq), .o_supply_detect_enable(o_supply_detect_enable),
    .o_regulator(o_regulator));
`default_nettype wire
